// file: hub_seq_top.sv
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "hub_seq_map.svh"
`default_nettype none

module hub_seq_top #(
  parameter int PORTS = 4,
  parameter int CNT_W = 24,
  parameter int AXI_AW = 8,
  parameter int RECOVER_CYC = `HUB_T_RECOVER_NS / `HUB_CLK_NS,
  parameter int LOAD_MAX_CYC = `HUB_T_LOAD_MAX_NS / `HUB_CLK_NS,
  parameter int REQ_MAX_CYC = `HUB_T_REQ_MAX_NS / `HUB_CLK_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  // board pins
  input wire logic ext_reset_n,
  input wire logic port_power_polarity_strap,
  input wire logic [1:0] cfg_sel_strap,
  input wire logic bus_powered,
  input wire logic [1:0] led_in,
  output logic [1:0] led_out,
  output logic [1:0] led_oe,
  output logic [PORTS-1:0] port_power_en,
  output logic osc_en,
  output logic pll_en,
  output logic phy_en,
  // hub core, same clock
  output logic core_abort,
  output logic eeprom_load_start,
  input wire logic eeprom_load_done,
  input wire logic smbus_load_done,
  output logic attach,
  input wire logic usb_bus_reset,
  output logic transaction_translator_flush,
  input wire logic set_address,
  input wire logic [6:0] new_address,
  input wire logic set_configured,
  input wire logic suspend_req,
  output logic suspended,
  input wire logic [PORTS-1:0] port_power_req,
  input wire logic [1:0] led_req,
  input wire logic ctrl_req_busy,
  output logic ctrl_req_expire,
  // axi4-lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SYN_W = 6;
  localparam int SETTLE_CYC = `HUB_T_SETTLE_NS / `HUB_CLK_NS;

  // pin synchronisers: the first stage feeds only the second
  logic [SYN_W-1:0] syn_a_q;
  logic [SYN_W-1:0] syn_b_q;
  wire [SYN_W-1:0] pins_raw = {ext_reset_n, port_power_polarity_strap, cfg_sel_strap, led_in};

  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          syn_a_q[gi] <= 1'b0;
          syn_b_q[gi] <= 1'b0;
        end else begin
          syn_a_q[gi] <= pins_raw[gi];
          syn_b_q[gi] <= syn_a_q[gi];
        end
      end
    end
  endgenerate

  wire hw_rst = ~syn_b_q[5];
  wire clr = !aresetn || hw_rst;

  // straps follow the pins while reset is held and freeze at release
  logic pol_q;
  logic [1:0] cfg_q;
  logic [1:0] led_strap_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_q <= 1'b1;
      cfg_q <= `HUB_CFG_DEFAULT;
      led_strap_q <= 2'h0;
    end else if (hw_rst) begin
      pol_q <= syn_b_q[4];
      cfg_q <= syn_b_q[3:2];
      led_strap_q <= syn_b_q[1:0];
    end
  end

  // sequencer
  hub_seq_pkg::hub_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q;
  logic load_to_q;
  wire cnt_clr = (st_q != st_d);
  wire recover_done = (st_q == hub_seq_pkg::HUB_ST_RECOVER) && (cnt_q == CNT_W'(RECOVER_CYC - 1));
  wire load_expired = (cnt_q == CNT_W'(LOAD_MAX_CYC - 1));
  wire smb_timed = bus_powered; // self-powered hub waits on the host alone
  wire bus_rst = usb_bus_reset && (st_q == hub_seq_pkg::HUB_ST_ACTIVE);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      hub_seq_pkg::HUB_ST_HOLD: st_d = hub_seq_pkg::HUB_ST_RECOVER;
      hub_seq_pkg::HUB_ST_RECOVER: begin
        if (recover_done) begin
          if (cfg_q == `HUB_CFG_EEPROM) begin
            st_d = hub_seq_pkg::HUB_ST_EE_LOAD;
          end else if (cfg_q == `HUB_CFG_SMBUS) begin
            st_d = hub_seq_pkg::HUB_ST_SMB_LOAD;
          end else begin
            st_d = hub_seq_pkg::HUB_ST_ACTIVE;
          end
        end
      end
      hub_seq_pkg::HUB_ST_EE_LOAD: begin
        if (eeprom_load_done || load_expired) begin
          st_d = hub_seq_pkg::HUB_ST_ACTIVE;
        end
      end
      hub_seq_pkg::HUB_ST_SMB_LOAD: begin
        if (smbus_load_done || (smb_timed && load_expired)) begin
          st_d = hub_seq_pkg::HUB_ST_ACTIVE;
        end
      end
      hub_seq_pkg::HUB_ST_ACTIVE: st_d = st_q;
      default: st_d = hub_seq_pkg::HUB_ST_HOLD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      st_q <= hub_seq_pkg::HUB_ST_HOLD;
      cnt_q <= '0;
      load_to_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_clr ? '0 : cnt_q + CNT_W'(1);
      if (load_expired && (st_q == hub_seq_pkg::HUB_ST_EE_LOAD)) begin
        load_to_q <= 1'b1;
      end
    end
  end

  // usb device state
  logic [6:0] addr_q;
  logic cfgd_q;
  logic susp_q;
  logic pwr_cut_q;
  always_ff @(posedge aclk) begin
    if (clr) begin
      addr_q <= 7'h00;
      cfgd_q <= 1'b0;
      susp_q <= 1'b0;
      pwr_cut_q <= 1'b1;
    end else if (bus_rst) begin
      addr_q <= 7'h00;
      cfgd_q <= 1'b0;
      susp_q <= 1'b0;
      pwr_cut_q <= 1'b1;
    end else begin
      if (set_address) begin
        addr_q <= new_address;
      end
      if (set_configured) begin
        cfgd_q <= 1'b1;
        pwr_cut_q <= 1'b0;
      end
      if (suspend_req) begin
        susp_q <= 1'b1;
      end
    end
  end

  // control request watchdog
  logic [CNT_W-1:0] req_cnt_q;
  logic expire_q;
  wire req_over = ctrl_req_busy && (req_cnt_q == CNT_W'(REQ_MAX_CYC - 1));
  // count parks one past the limit so a long request gives a single expiry pulse
  wire req_sat = (req_cnt_q == CNT_W'(REQ_MAX_CYC));
  always_ff @(posedge aclk) begin
    if (clr || !ctrl_req_busy) begin
      req_cnt_q <= '0;
      expire_q <= 1'b0;
    end else begin
      req_cnt_q <= req_sat ? req_cnt_q : req_cnt_q + CNT_W'(1);
      expire_q <= req_over;
    end
  end

  // software control register
  logic [31:0] ctrl_q;
  wire detach = ctrl_q[`HUB_CTRL_DETACH];
  wire [PORTS-1:0] port_dis = ctrl_q[`HUB_CTRL_PDIS_LO +: PORTS];

  // settle count after release, used to gate phy_en and led_oe out of their inactive level
  logic [CNT_W-1:0] settle_q;
  wire settled = (settle_q == CNT_W'(SETTLE_CYC));
  always_ff @(posedge aclk) begin
    if (clr) begin
      settle_q <= '0;
    end else if (!settled) begin
      settle_q <= settle_q + CNT_W'(1);
    end
  end

  wire active = (st_q == hub_seq_pkg::HUB_ST_ACTIVE);
  // downstream ports never see the upstream reset as a reset, only as power removal
  wire [PORTS-1:0] pwr_on = (active && !pwr_cut_q) ? (port_power_req & ~port_dis) : '0;
  // strap high means active-low drive
  wire [1:0] led_lvl = led_req ^ led_strap_q;

  always_ff @(posedge aclk) begin
    if (clr) begin
      port_power_en <= {PORTS{~pol_q}};
      osc_en <= 1'b0;
      pll_en <= 1'b0;
      phy_en <= 1'b0;
      led_oe <= 2'h0;
      led_out <= 2'h0;
      core_abort <= 1'b1;
      eeprom_load_start <= 1'b0;
      attach <= 1'b0;
      transaction_translator_flush <= 1'b0;
      suspended <= 1'b0;
      ctrl_req_expire <= 1'b0;
    end else begin
      port_power_en <= pol_q ? pwr_on : ~pwr_on;
      osc_en <= 1'b1;
      pll_en <= 1'b1;
      phy_en <= settled;
      led_oe <= {2{settled && active}};
      led_out <= led_lvl;
      core_abort <= 1'b0;
      eeprom_load_start <= (st_q != hub_seq_pkg::HUB_ST_EE_LOAD) && (st_d == hub_seq_pkg::HUB_ST_EE_LOAD);
      attach <= active && !detach;
      transaction_translator_flush <= bus_rst;
      suspended <= susp_q;
      ctrl_req_expire <= expire_q;
    end
  end

  // axi4-lite write path: address and data taken in either order
  logic aw_have_q;
  logic w_have_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire aw_have_d = (aw_have_q || aw_take) && !wr_fire;
  wire w_have_d = (w_have_q || w_take) && !wr_fire;
  wire wr_ctrl = wr_fire && (awaddr_q[7:0] == `HUB_REG_CTRL);
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HUB_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_have_d;
      s_axi_wready <= !w_have_d;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      ctrl_q <= `HUB_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
    end
  end

  // axi4-lite read path; unmapped offsets read zero with an okay answer
  wire [31:0] status_word = {16'h0000, 3'h0, load_to_q, pol_q, led_strap_q, cfg_q, hw_rst, active, st_q, 2'h0};
  wire [31:0] usb_word = {19'h00000, port_power_req, susp_q, cfgd_q, addr_q[6:1], addr_q[0]};
  wire [7:0] rd_off = s_axi_araddr[7:0];
  wire [31:0] rd_mux = (rd_off == `HUB_REG_CTRL) ? ctrl_q :
                       (rd_off == `HUB_REG_STATUS) ? status_word :
                       (rd_off == `HUB_REG_USB) ? usb_word : 32'h0000_0000;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `HUB_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // hub_seq_top

`default_nettype wire

// file: hub_seq_map.svh
`ifndef HUB_SEQ_MAP_SVH
`define HUB_SEQ_MAP_SVH

// clock period and documented times, in nanoseconds
`define HUB_CLK_NS 10
`define HUB_T_RECOVER_NS 500000
`define HUB_T_SETTLE_NS 1500
`define HUB_T_LOAD_MAX_NS 99500000
`define HUB_T_REQ_MAX_NS 5000000

// register byte offsets
`define HUB_REG_CTRL 8'h00
`define HUB_REG_STATUS 8'h04
`define HUB_REG_USB 8'h08

// control register fields
`define HUB_CTRL_DETACH 0
`define HUB_CTRL_PDIS_LO 4
`define HUB_CTRL_PDIS_HI 7
`define HUB_CTRL_RST 32'h0000_0000

// strap codes on the two configuration-select pins
`define HUB_CFG_DEFAULT 2'h0
`define HUB_CFG_EEPROM 2'h1
`define HUB_CFG_SMBUS 2'h2

// axi answers
`define HUB_RESP_OKAY 2'h0

`endif

// file: hub_seq_pkg.sv
`default_nettype none
package hub_seq_pkg;

  typedef enum logic [2:0] {
    HUB_ST_HOLD = 3'b000,
    HUB_ST_RECOVER = 3'b001,
    HUB_ST_EE_LOAD = 3'b010,
    HUB_ST_SMB_LOAD = 3'b011,
    HUB_ST_ACTIVE = 3'b100
  } hub_state_e;

endpackage
`default_nettype wire

// file: hub_seq_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module hub_seq_checker #(
  parameter int PORTS = 4,
  parameter int RECOVER_CYC = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_reset_n,
  input wire logic port_power_polarity_strap,
  input wire logic [1:0] cfg_sel_strap,
  input wire logic [1:0] led_oe,
  input wire logic [PORTS-1:0] port_power_en,
  input wire logic osc_en,
  input wire logic pll_en,
  input wire logic phy_en,
  input wire logic core_abort,
  input wire logic eeprom_load_start,
  input wire logic attach,
  input wire logic usb_bus_reset,
  input wire logic transaction_translator_flush,
  input wire logic suspended
);
  localparam int ATT_LO = RECOVER_CYC;
  localparam int ATT_HI = RECOVER_CYC + 8;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // four low samples cover the two-flop synchroniser plus the output register
  chk_hw_quiet: assert property (
    !ext_reset_n [*4] |-> !osc_en && !pll_en && !phy_en && led_oe == 2'h0 && core_abort)
    else $error("outputs live in hardware reset");
  // one sample more: the polarity is latched from the synchronised strap before it drives the ports
  chk_hw_ports: assert property (
    (!ext_reset_n && port_power_polarity_strap) [*5] |-> port_power_en == '0)
    else $error("ports powered in hardware reset");
  chk_recover_min: assert property ($rose(ext_reset_n) |-> not ##[1:ATT_LO] attach)
    else $error("attach before recovery");
  chk_attach_max: assert property (
    $rose(ext_reset_n) && cfg_sel_strap == 2'h0 |-> ##[ATT_LO:ATT_HI] attach)
    else $error("attach late");
  chk_ee_start: assert property (
    $rose(ext_reset_n) && cfg_sel_strap == 2'h1 |-> ##[ATT_LO:ATT_HI] eeprom_load_start)
    else $error("eeprom load late");
  chk_tt_flush: assert property (usb_bus_reset && attach |=> transaction_translator_flush)
    else $error("no flush");
  chk_bus_power: assert property (
    usb_bus_reset && attach |-> ##2 port_power_en == {PORTS{~port_power_polarity_strap}})
    else $error("ports powered after bus reset");
  chk_bus_wake: assert property (usb_bus_reset && attach |-> ##2 !suspended)
    else $error("still suspended");
  cov_attach: cover property ($rose(attach));
  cov_flush: cover property (transaction_translator_flush);
  cov_ee: cover property (eeprom_load_start);
endmodule // hub_seq_checker
bind hub_seq_top hub_seq_checker #(.PORTS(PORTS), .RECOVER_CYC(RECOVER_CYC)) u_hub_seq_checker (
  .aclk(aclk),
  .aresetn(aresetn),
  .ext_reset_n(ext_reset_n),
  .port_power_polarity_strap(port_power_polarity_strap),
  .cfg_sel_strap(cfg_sel_strap),
  .led_oe(led_oe),
  .port_power_en(port_power_en),
  .osc_en(osc_en),
  .pll_en(pll_en),
  .phy_en(phy_en),
  .core_abort(core_abort),
  .eeprom_load_start(eeprom_load_start),
  .attach(attach),
  .usb_bus_reset(usb_bus_reset),
  .transaction_translator_flush(transaction_translator_flush),
  .suspended(suspended)
);
`default_nettype wire

// file: hub_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// upstream host: after attach it waits, then signals one bus reset
module hub_host_model #(
  parameter int WAIT_CYC = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic attach,
  input wire logic go,
  output logic usb_bus_reset,
  output logic done
);
  logic [15:0] cnt_q;
  logic hit;
  assign hit = (cnt_q == 16'(WAIT_CYC));
  always_ff @(posedge aclk) begin
    if (!aresetn || !go || !attach) begin
      cnt_q <= 16'h0;
      usb_bus_reset <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt_q <= hit ? cnt_q : cnt_q + 16'h1;
      usb_bus_reset <= hit && !done;
      done <= done || hit;
    end
  end
endmodule // hub_host_model
`default_nettype wire

// file: hub_reset_and_startup_sequencer_test.sv
`timescale 1ns/100ps
`include "hub_seq_map.svh"
`default_nettype none
module hub_reset_and_startup_sequencer_test;
  localparam int RCYC = 20;
  localparam int QCYC = 30;
  logic aclk, aresetn, ext_reset_n, port_power_polarity_strap, bus_powered, eeprom_load_done, smbus_load_done;
  logic usb_bus_reset, set_address, set_configured, suspend_req, ctrl_req_busy, host_go, host_done;
  logic attach, eeprom_load_start, transaction_translator_flush, suspended, ctrl_req_expire;
  logic osc_en, pll_en, phy_en, core_abort, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] cfg_sel_strap, led_in, led_out, led_oe, led_req, s_axi_bresp, s_axi_rresp;
  logic [3:0] port_power_en, port_power_req, s_axi_wstrb;
  logic [6:0] new_address;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  int num_errors, samples_checked, n;
  hub_seq_top #(.RECOVER_CYC(RCYC), .LOAD_MAX_CYC(50), .REQ_MAX_CYC(QCYC)) u_hub_seq_top (.*);
  hub_host_model #(.WAIT_CYC(40)) u_hub_host_model (.aclk(aclk), .aresetn(aresetn), .attach(attach),
    .go(host_go), .usb_bus_reset(usb_bus_reset), .done(host_done));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(`HUB_RESP_OKAY));
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", 32'(s_axi_rresp), 32'(`HUB_RESP_OKAY));
  endtask
  // which: 0 attach, 1 eeprom start, 2 request expiry, 3 host done
  task automatic wait_hi(input int which, input int lim);
    logic [3:0] s;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      s = {host_done, ctrl_req_expire, eeprom_load_start, attach};
    end while (s[which] !== 1'b1 && n < lim);
    chk("wait", 32'(s[which]), 32'h1);
  endtask
  task automatic hw_reset(input logic pol, input logic [1:0] cfg, input logic [1:0] led);
    @(posedge aclk);
    ext_reset_n <= 1'b0;
    port_power_polarity_strap <= pol;
    cfg_sel_strap <= cfg;
    led_in <= led;
    repeat (100) @(posedge aclk);
    chk("quiet", {27'h0, osc_en, pll_en, phy_en, led_oe}, 32'h0);
    chk("abort", 32'(core_abort), 32'h1);
    chk("ports", 32'(port_power_en), pol ? 32'h0 : 32'hf);
    ext_reset_n <= 1'b1;
  endtask
  task automatic strobe_cfg;
    set_configured <= 1'b1;
    @(posedge aclk);
    set_configured <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    {aresetn, ext_reset_n, bus_powered, eeprom_load_done, smbus_load_done, set_address, set_configured} = '0;
    {suspend_req, ctrl_req_busy, host_go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, port_power_polarity_strap, cfg_sel_strap, led_in, led_req, port_power_req} = '0;
    {new_address, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    hw_reset(1'b1, `HUB_CFG_DEFAULT, 2'h1);
    wait_hi(0, RCYC + 20);
    led_req <= 2'h3;
    repeat (150) @(posedge aclk);
    chk("phy", 32'(phy_en), 32'h1);
    chk("clocks", {30'h0, osc_en, pll_en}, 32'h3);
    chk("leds", {28'h0, led_oe, led_out}, 32'he);
    axi_rd(`HUB_REG_STATUS, rd);
    chk("status", rd, {19'h0, 2'h1, 2'h1, 2'h0, 2'h1, 3'h4, 2'h0});
    port_power_req <= 4'hf;
    set_address <= 1'b1;
    new_address <= 7'h2a;
    strobe_cfg();
    set_address <= 1'b0;
    chk("powered", 32'(port_power_en), 32'hf);
    axi_rd(`HUB_REG_USB, rd);
    chk("usb", rd, {19'h0, 4'hf, 2'h1, 7'h2a});
    suspend_req <= 1'b1;
    @(posedge aclk);
    suspend_req <= 1'b0;
    host_go <= 1'b1;
    wait_hi(3, 80);
    repeat (3) @(posedge aclk);
    chk("bus_rst_ports", 32'(port_power_en), 32'h0);
    axi_rd(`HUB_REG_USB, rd);
    chk("usb_rst", rd, {19'h0, 4'hf, 2'h0, 7'h0});
    ctrl_req_busy <= 1'b1;
    wait_hi(2, QCYC + 5);
    chk("expire_at", 32'(n >= QCYC && n <= QCYC + 2), 32'h1);
    ctrl_req_busy <= 1'b0;
    axi_wr(`HUB_REG_CTRL, 32'h1);
    axi_rd(`HUB_REG_CTRL, rd);
    chk("ctrl", rd, 32'h1);
    axi_rd(8'h40, rd);
    chk("unmapped", rd, 32'h0);
    hw_reset(1'b0, `HUB_CFG_EEPROM, 2'h0);
    axi_rd(`HUB_REG_CTRL, rd);
    chk("ctrl_rst", rd, 32'h0);
    wait_hi(1, RCYC + 20);
    repeat (5) @(posedge aclk);
    eeprom_load_done <= 1'b1;
    @(posedge aclk);
    eeprom_load_done <= 1'b0;
    wait_hi(0, 20);
    chk("pol_off", 32'(port_power_en), 32'hf);
    strobe_cfg();
    chk("pol_on", 32'(port_power_en), 32'h0);
    bus_powered <= 1'b1;
    hw_reset(1'b1, `HUB_CFG_SMBUS, 2'h0);
    repeat (RCYC + 10) @(posedge aclk);
    chk("smb_wait", 32'(attach), 32'h0);
    smbus_load_done <= 1'b1;
    @(posedge aclk);
    smbus_load_done <= 1'b0;
    wait_hi(0, 20);
    complete_run();
  end
  // the whole sequence needs about 700 cycles
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    complete_run();
  end
endmodule // hub_reset_and_startup_sequencer_test
`default_nettype wire
